// ---- logic/bcs_pkg.sv ----
package bcs_pkg;

	// Configuration byte offsets; a dword is selected by offset[7:2].
	localparam logic [7:0] STATUS_OFFSET = 8'h06;
	localparam logic [7:0] CLASS_OFFSET = 8'h08;
	localparam logic [7:0] LINE_SIZE_OFFSET = 8'h0C;

	// Byte lanes of the 32-bit access port, and the lowest bit of the status lanes.
	localparam int STATUS_LANE_LSB = 16;
	localparam int STATUS_HIGH_LANE = 3;
	localparam int LINE_SIZE_LANE = 0;

	// Status field positions.
	localparam int DETECTED_POISON_BIT = 15;
	localparam int SIGNALED_SYSTEM_ERROR_BIT = 14;
	localparam int RECEIVED_UNSUPPORTED_BIT = 13;
	localparam int RECEIVED_COMPLETER_ABORT_BIT = 12;
	localparam int SIGNALED_COMPLETER_ABORT_BIT = 11;
	localparam int MASTER_DATA_POISON_BIT = 8;
	localparam int EXTRA_CAPABILITIES_BIT = 4;

	// Bits that hold sticky error flags, and the constant part of the status word.
	localparam logic [15:0] FLAG_MASK = 16'hF900;
	localparam logic [15:0] STATUS_CONST = 16'h0010;
	localparam logic [15:0] STATUS_RESET = 16'h0010;

	// Class code fields.
	localparam logic [7:0] BASE_CATEGORY = 8'h06;
	localparam logic [7:0] SUB_CATEGORY = 8'h04;
	localparam logic [7:0] PROGRAMMING_INTERFACE = 8'h00;

	// Cache line size.
	localparam logic [7:0] LINE_SIZE_RESET = 8'h00;
	localparam logic [7:0] LINE_SIZE_MAX_DW = 8'h20;

	typedef struct packed {
		logic write;
		logic [7:0] addr;
		logic [3:0] byteEn;
		logic [31:0] wrData;
	} bcs_cfg_req_t;

	typedef struct packed {
		logic poisonedTlp;
		logic errMsgSent;
		logic cplUnsupported;
		logic cplCompleterAbort;
		logic completerAbortSent;
		logic poisonedCplData;
		logic poisonedWrite;
	} bcs_event_t;

endpackage

// ---- logic/bcs_sticky_flag.sv ----
`timescale 1ns/100ps
module bcs_sticky_flag (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic set,
	input wire logic clear,
	output logic flag
);
	logic next_flag;

	// Set wins over a clear in the same cycle so that no event is lost.
	always_comb begin
		next_flag = flag;
		if (clear) begin
			next_flag = 1'b0;
		end
		if (set) begin
			next_flag = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flag <= 1'b0;
		end else begin
			flag <= next_flag;
		end
	end
endmodule

// ---- logic/bcs_config_regs.sv ----
`timescale 1ns/100ps
// Function
// RULE_01 - Poisoned packet received upstream sets status bit 15, regardless of parity enable.
// RULE_02 - Error message sent upstream sets bit 14, only while system error enable set.
// RULE_03 - Completion with unsupported-request status received sets status bit 13.
// RULE_04 - Completion with completer-abort status received sets status bit 12.
// RULE_05 - Upstream port answering with completer-abort status sets status bit 11.
// RULE_06 - Status bits 10:9 always read zero and ignore writes.
// RULE_07 - With parity enable, poisoned completion data or poisoned write sets bit 8.
// RULE_08 - Status bits 7, 6, 5 and 2:0 read zero and ignore writes.
// RULE_09 - Status bit 4 always reads one: capability list present.
// RULE_10 - Status bit 3, interrupt pending, reads constant zero.
// RULE_11 - Error flags clear by writing one; zero leaves them; reset clears all.
// RULE_12 - Class register reads base 06h, subclass 04h, interface 00h.
// RULE_13 - Class register bits 7:0 read the silicon revision code.
// RULE_14 - Cache line size sets the prefetch amount for delayed reads.
// RULE_15 - Software writes only powers of two into the cache line size.
// RULE_16 - Odd values or values above 32 dwords act as zero dwords.
// RULE_17 - With system error enable clear, no error reports for secondary system errors.
// RULE_18 - Parity enable gates only the master data poison flag, not forwarding.
module bcs_config_regs #(
	parameter logic [7:0] SILICON_REVISION = 8'h5A
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cfgValid,
	input wire bcs_pkg::bcs_cfg_req_t cfgIn,
	output logic cfgAck,
	output logic [31:0] cfgRdData,
	input wire logic parityResponseEnable,
	input wire logic systemErrorReportEnable,
	input wire bcs_pkg::bcs_event_t linkEvent,
	input wire logic secondarySystemError,
	output logic errorReportRequest,
	output logic [7:0] prefetchDwords,
	output logic [15:0] statusFlags
);
	// The revision value above is arbitrary.

	logic hitStatus;
	logic hitClass;
	logic hitLineSize;
	logic statusWrite;
	logic lineSizeWrite;
	logic [15:0] setVec;
	logic [15:0] clearVec;
	logic [15:0] flagVec;
	logic [15:0] statusValue;
	logic [7:0] lineSize;
	logic [7:0] next_lineSize;
	logic [7:0] next_prefetchDwords;
	logic next_cfgAck;
	logic [31:0] next_cfgRdData;
	logic next_errorReportRequest;
	logic [15:0] next_statusFlags;

	assign hitStatus = cfgIn.addr[7:2] == bcs_pkg::STATUS_OFFSET[7:2];
	assign hitClass = cfgIn.addr[7:2] == bcs_pkg::CLASS_OFFSET[7:2];
	assign hitLineSize = cfgIn.addr[7:2] == bcs_pkg::LINE_SIZE_OFFSET[7:2];
	assign statusWrite = cfgValid && cfgIn.write && hitStatus &&
		cfgIn.byteEn[bcs_pkg::STATUS_HIGH_LANE];
	assign lineSizeWrite = cfgValid && cfgIn.write && hitLineSize &&
		cfgIn.byteEn[bcs_pkg::LINE_SIZE_LANE];

	// Event to flag mapping; the enables come from the command register outside.
	always_comb begin
		setVec = 16'h0000;
		setVec[bcs_pkg::DETECTED_POISON_BIT] = linkEvent.poisonedTlp; // see RULE_01
		setVec[bcs_pkg::SIGNALED_SYSTEM_ERROR_BIT] = linkEvent.errMsgSent &&
			systemErrorReportEnable; // see RULE_02
		setVec[bcs_pkg::RECEIVED_UNSUPPORTED_BIT] = linkEvent.cplUnsupported; // see RULE_03
		setVec[bcs_pkg::RECEIVED_COMPLETER_ABORT_BIT] =
			linkEvent.cplCompleterAbort; // see RULE_04
		setVec[bcs_pkg::SIGNALED_COMPLETER_ABORT_BIT] =
			linkEvent.completerAbortSent; // see RULE_05
		// Only this flag sees the parity enable; forwarding of poisoned data is not touched here.
		setVec[bcs_pkg::MASTER_DATA_POISON_BIT] = parityResponseEnable &&
			(linkEvent.poisonedCplData || linkEvent.poisonedWrite); // see RULE_07 see RULE_18
	end

	// Write one to clear; all flags live in the high status byte.
	always_comb begin
		clearVec = 16'h0000;
		if (statusWrite) begin
			clearVec = cfgIn.wrData[31:bcs_pkg::STATUS_LANE_LSB] & bcs_pkg::FLAG_MASK; // see RULE_11
		end
	end

	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : gFlag
			if (bcs_pkg::FLAG_MASK[i]) begin : gSticky
				bcs_sticky_flag uFlag (
					.clk_sys(clk_sys),
					.rst(rst),
					.set(setVec[i]),
					.clear(clearVec[i]),
					.flag(flagVec[i])
				); // see RULE_11
			end else begin : gConst
				assign flagVec[i] = 1'b0;
			end
		end
	endgenerate

	// Constant bits: 10:9, 7:5, 3 and 2:0 zero, bit 4 one.
	assign statusValue = flagVec | bcs_pkg::STATUS_CONST; // see RULE_06 RULE_08 RULE_09 RULE_10

	// Cache line size keeps the raw value for read-back; the prefetch amount is filtered.
	always_comb begin
		next_lineSize = lineSize;
		if (lineSizeWrite) begin
			next_lineSize = cfgIn.wrData[7:0];
		end
		if (next_lineSize[0] || next_lineSize > bcs_pkg::LINE_SIZE_MAX_DW) begin
			next_prefetchDwords = 8'h00; // see RULE_16
		end else begin
			next_prefetchDwords = next_lineSize; // see RULE_14
		end
	end

	// Reads return the state before any write of the same access.
	always_comb begin
		next_cfgAck = cfgValid;
		next_cfgRdData = 32'h00000000;
		if (cfgValid && !cfgIn.write) begin
			if (hitStatus) begin
				next_cfgRdData = {statusValue, 16'h0000};
			end else if (hitClass) begin
				next_cfgRdData = {bcs_pkg::BASE_CATEGORY, bcs_pkg::SUB_CATEGORY,
					bcs_pkg::PROGRAMMING_INTERFACE, SILICON_REVISION}; // see RULE_12 see RULE_13
			end else if (hitLineSize) begin
				next_cfgRdData = {24'h000000, lineSize};
			end
		end
	end

	// Secondary system errors are reported upstream only while enabled.
	always_comb begin
		next_errorReportRequest = secondarySystemError && systemErrorReportEnable; // see RULE_17
		next_statusFlags = statusValue;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lineSize <= bcs_pkg::LINE_SIZE_RESET;
			prefetchDwords <= bcs_pkg::LINE_SIZE_RESET;
		end else begin
			lineSize <= next_lineSize;
			prefetchDwords <= next_prefetchDwords;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cfgAck <= 1'b0;
			cfgRdData <= 32'h00000000;
		end else begin
			cfgAck <= next_cfgAck;
			cfgRdData <= next_cfgRdData;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			errorReportRequest <= 1'b0;
			statusFlags <= bcs_pkg::STATUS_RESET;
		end else begin
			errorReportRequest <= next_errorReportRequest;
			statusFlags <= next_statusFlags;
		end
	end

	// Helper terms read only by the checks below.
	logic readStatus;
	logic readClass;
	logic readLineSize;
	logic [7:0] wrByte0;
	logic [15:0] wrStatus;
	assign readStatus = cfgValid && !cfgIn.write && hitStatus;
	assign readClass = cfgValid && !cfgIn.write && hitClass;
	assign readLineSize = cfgValid && !cfgIn.write && hitLineSize;
	assign wrByte0 = cfgIn.wrData[7:0];
	assign wrStatus = cfgIn.wrData[31:16];

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	poison_flag_a: assert property ( // see RULE_01
		linkEvent.poisonedTlp |-> ##2 statusFlags[15])
		else $error("Detected poison flag not set after poisoned packet.");

	signaled_system_error_flag_set_a: assert property ( // see RULE_02
		linkEvent.errMsgSent && systemErrorReportEnable |=> flagVec[14] ##1 statusFlags[14])
		else $error("System error flag not set after error message.");

	signaled_system_error_flag_gate_a: assert property ( // see RULE_02
		!flagVec[14] && !(linkEvent.errMsgSent && systemErrorReportEnable) |=> !flagVec[14])
		else $error("System error flag set without enable.");

	unsupported_flag_a: assert property ( // see RULE_03
		linkEvent.cplUnsupported |=> flagVec[13])
		else $error("Unsupported completion flag not set.");

	abort_recv_a: assert property ( // see RULE_04
		linkEvent.cplCompleterAbort |=> flagVec[12])
		else $error("Received completer abort flag not set.");

	abort_sent_a: assert property ( // see RULE_05
		linkEvent.completerAbortSent |=> flagVec[11])
		else $error("Signaled completer abort flag not set.");

	status_const_a: assert property ( // see RULE_06 see RULE_08 see RULE_09 see RULE_10
		readStatus |=> (cfgRdData[31:16] & 16'h06FF) == 16'h0010)
		else $error("Constant status bits read wrong.");

	data_poison_gate_a: assert property ( // see RULE_07
		!flagVec[8] && !parityResponseEnable |=> !flagVec[8])
		else $error("Master data poison flag set while parity response disabled.");

	data_poison_set_a: assert property ( // see RULE_07
		parityResponseEnable && linkEvent.poisonedWrite |=> flagVec[8])
		else $error("Master data poison flag not set on poisoned write.");

	flag_clear_a: assert property ( // see RULE_11
		statusWrite && wrStatus[15] && !linkEvent.poisonedTlp |=> !flagVec[15])
		else $error("Write of one did not clear detected poison flag.");

	flag_hold_a: assert property ( // see RULE_11
		statusWrite && !wrStatus[13] && flagVec[13] |=> flagVec[13])
		else $error("Write of zero disturbed a flag.");

	class_read_a: assert property ( // see RULE_12 see RULE_13
		readClass |=> cfgAck && cfgRdData == {8'h06, 8'h04, 8'h00, SILICON_REVISION})
		else $error("Class and revision read wrong.");

	prefetch_odd_a: assert property ( // see RULE_16
		lineSizeWrite && (wrByte0[0] || wrByte0 > 8'h20) |=> prefetchDwords == 8'h00)
		else $error("Illegal line size not treated as zero.");

	prefetch_ok_a: assert property ( // see RULE_14
		lineSizeWrite && !wrByte0[0] && wrByte0 <= 8'h20 |=> prefetchDwords == $past(wrByte0))
		else $error("Prefetch amount does not follow line size.");

	err_report_a: assert property ( // see RULE_17
		secondarySystemError && !systemErrorReportEnable |=> !errorReportRequest)
		else $error("Error reported while system error enable clear.");

	poison_ungated_a: assert property ( // see RULE_01
		linkEvent.poisonedTlp && !parityResponseEnable |=> flagVec[15])
		else $error("Detected poison flag gated by parity enable.");

	set_wins_a: assert property ( // see RULE_11
		statusWrite && wrStatus[15] && linkEvent.poisonedTlp |=> flagVec[15])
		else $error("Clear of detected poison flag lost a new event.");

	data_poison_cpl_a: assert property ( // see RULE_07
		parityResponseEnable && linkEvent.poisonedCplData |=> flagVec[8])
		else $error("Master data poison flag not set on poisoned completion.");

	poison_clear_a: assert property ( // see RULE_11
		statusWrite && wrStatus[8] && !setVec[8] |=> !flagVec[8])
		else $error("Write of one did not clear master data poison flag.");

	status_lane_a: assert property ( // see RULE_11
		cfgValid && cfgIn.write && hitStatus && !cfgIn.byteEn[bcs_pkg::STATUS_HIGH_LANE] &&
		flagVec[11] |=> flagVec[11])
		else $error("Status flag cleared without its byte enabled.");

	err_report_on_a: assert property ( // see RULE_17
		secondarySystemError && systemErrorReportEnable |=> errorReportRequest)
		else $error("Secondary system error not passed upstream while enabled.");

	ack_pulse_a: assert property ( // see RULE_12
		cfgValid |=> cfgAck)
		else $error("Access not acknowledged one cycle later.");

	ack_idle_a: assert property ( // see RULE_12
		!cfgValid |=> !cfgAck)
		else $error("Acknowledge without an access.");

	line_read_a: assert property ( // see RULE_14
		readLineSize |=> cfgRdData == {24'h000000, $past(lineSize)})
		else $error("Line size read back wrong.");

	line_hold_a: assert property ( // see RULE_14
		!lineSizeWrite |=> lineSize == $past(lineSize))
		else $error("Line size changed without an enabled write.");

	prefetch_hold_a: assert property ( // see RULE_14
		!lineSizeWrite |=> prefetchDwords == $past(prefetchDwords))
		else $error("Prefetch amount changed without a line size write.");

	write_data_zero_a: assert property ( // see RULE_12
		cfgValid && cfgIn.write |=> cfgRdData == 32'h00000000)
		else $error("Write returned read data.");

	unmapped_read_a: assert property ( // see RULE_12
		cfgValid && !cfgIn.write && !hitStatus && !hitClass && !hitLineSize |=>
		cfgRdData == 32'h00000000)
		else $error("Unmapped dword did not read zero.");

	clear_race_c: cover property (statusWrite && wrStatus[15] && linkEvent.poisonedTlp);
	class_read_c: cover property (readClass ##1 cfgAck);
	line_size_c: cover property (lineSizeWrite && wrByte0 == 8'h10);
	data_poison_c: cover property (parityResponseEnable && linkEvent.poisonedCplData);
	err_report_c: cover property (secondarySystemError && systemErrorReportEnable ##1 errorReportRequest);
endmodule

// ---- tb/bcs_host_model.sv ----
`timescale 1ns/100ps
// Upstream configuration requester; one access at a time, held up to its taking edge.
module bcs_host_model (
	input wire logic clk_sys,
	output logic cfgValid,
	output bcs_pkg::bcs_cfg_req_t cfgIn
);
	initial begin
		cfgValid = 1'b0;
		cfgIn = '0;
	end
	// Line size values come from the caller; odd or oversize only where a test asks.
	task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
			input logic [31:0] data);
		@(posedge clk_sys);
		cfgValid <= 1'b1;
		cfgIn <= '{write: wr, addr: addr, byteEn: be, wrData: data};
		@(posedge clk_sys);
		cfgValid <= 1'b0;
		// Idle fields are inverted so a stale request never looks like a live one.
		cfgIn <= ~cfgIn;
	endtask
endmodule

// ---- tb/bcs_config_regs_test.sv ----
`timescale 1ns/100ps
module bcs_config_regs_test;
	localparam logic [7:0] REV = 8'h3C; // Arbitrary revision value.
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic parityEn = 1'b0;
	logic sysErrEn = 1'b0;
	logic secErr = 1'b0;
	logic prevGate = 1'b0;
	logic cfgValid;
	logic cfgAck;
	logic errReq;
	logic [31:0] rdData;
	logic [31:0] data;
	logic [7:0] prefetch;
	logic [7:0] lsz;
	logic [15:0] flags;
	logic [15:0] expStatus = 16'h0010;
	bcs_pkg::bcs_cfg_req_t cfgIn;
	bcs_pkg::bcs_event_t ev = '0;
	logic [31:0] expQ[$];
	logic [31:0] rnd = 32'h00000032;
	logic [7:0] sizes[8] = '{8'h00, 8'h01, 8'h02, 8'h20, 8'h21, 8'h40, 8'h10, 8'hFE};
	int errCount = 0;
	int checksDone = 0;
	int cycles = 0;

	always #20 clk_sys = ~clk_sys;

	bcs_host_model host (.clk_sys(clk_sys), .cfgValid(cfgValid), .cfgIn(cfgIn));
	bcs_config_regs #(.SILICON_REVISION(REV)) dut (.clk_sys(clk_sys), .rst(rst),
		.cfgValid(cfgValid), .cfgIn(cfgIn), .cfgAck(cfgAck), .cfgRdData(rdData),
		.parityResponseEnable(parityEn), .systemErrorReportEnable(sysErrEn), .linkEvent(ev),
		.secondarySystemError(secErr), .errorReportRequest(errReq), .prefetchDwords(prefetch),
		.statusFlags(flags));

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errCount++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
		expQ.push_back(exp);
		host.access(1'b0, addr, 4'hF, 32'h0);
	endtask

	task automatic wr(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] d);
		expQ.push_back(32'h0);
		host.access(1'b1, addr, be, d);
	endtask

	task automatic fire(input bcs_pkg::bcs_event_t e);
		@(posedge clk_sys);
		ev <= e;
		@(posedge clk_sys);
		ev <= '0;
		expStatus |= {e.poisonedTlp, e.errMsgSent & sysErrEn, e.cplUnsupported,
			e.cplCompleterAbort, e.completerAbortSent, 2'b00,
			(e.poisonedCplData | e.poisonedWrite) & parityEn, 8'h00};
	endtask

	task automatic do_reset(input int n);
		@(posedge clk_sys);
		secErr <= 1'b0;
		rst <= 1'b1;
		repeat (n) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		expStatus = 16'h0010;
		check({16'h0, flags}, 32'h0010);
		check({24'h0, prefetch}, 32'h0);
		rd(8'h06, 32'h0010_0000);
		rd(8'h0C, 32'h0);
		$display("test reset done");
	endtask

	task finish_test;
		$display("checks %0d, mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Every acknowledge retires the oldest note; writes expect zero read data.
	always @(posedge clk_sys) begin
		if (!rst && cfgAck === 1'b1)
			check(rdData, expQ.pop_front());
		if (!rst)
			check({31'h0, errReq}, {31'h0, prevGate});
		prevGate <= secErr & sysErrEn;
	end

	// The limit allows about three times the expected run length.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 1500) begin
			errCount++;
			finish_test();
		end
	end

	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		check({16'h0, flags}, 32'h0010);
		rd(8'h06, 32'h0010_0000);
		for (int i = 0; i < 40; i++) begin
			rnd = xorshift(rnd);
			data = xorshift(rnd);
			@(posedge clk_sys);
			parityEn <= rnd[0];
			sysErrEn <= rnd[1];
			secErr <= rnd[2];
			@(posedge clk_sys);
			fire(bcs_pkg::bcs_event_t'(rnd[14:8]));
			rd(8'h06, {expStatus, 16'h0000});
			wr(8'h04, rnd[19:16], data);
			if (rnd[19])
				expStatus &= ~(data[31:16] & bcs_pkg::FLAG_MASK);
		end
		repeat (2) @(posedge clk_sys);
		check({16'h0, flags}, {16'h0, expStatus});
		rd(8'h06, {expStatus, 16'h0000});
		// A new event must survive a clear that lands in the same cycle.
		fork
			fire(bcs_pkg::bcs_event_t'(7'h40));
			wr(8'h04, 4'h8, 32'hF900_0000);
		join
		expStatus = bcs_pkg::STATUS_CONST | 16'h8000;
		rd(8'h06, {expStatus, 16'h0000});
		$display("test status done");
		wr(8'h08, 4'hF, 32'hFFFF_FFFF);
		rd(8'h08, {8'h06, 8'h04, 8'h00, REV});
		wr(8'h10, 4'hF, 32'hFFFF_FFFF);
		rd(8'h10, 32'h0);
		$display("test class done");
		for (int i = 0; i < 8; i++) begin
			lsz = sizes[i];
			rnd = xorshift(rnd);
			wr(8'h0C, 4'h1, {rnd[31:8], lsz});
			wr(8'h0C, 4'hE, rnd);
			rd(8'h0C, {24'h0, lsz});
			repeat (2) @(posedge clk_sys);
			check({24'h0, prefetch}, {24'h0, (lsz[0] || lsz > 8'h20) ? 8'h00 : lsz});
		end
		$display("test line size done");
		@(posedge clk_sys);
		parityEn <= 1'b1;
		sysErrEn <= 1'b1;
		fire('1);
		wr(8'h0C, 4'h1, 32'h10);
		do_reset(3);
		repeat (3) @(posedge clk_sys);
		check(32'(expQ.size()), 32'h00000000);
		finish_test();
	end
endmodule
